/* File: bench/ext_ctrl_checker.sv */
// port assertions for the extended control block
`timescale 1ns/1ps
module ext_ctrl_checker
  import ext_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire mgmt_req_t i_mgmt_req,
  input wire logic i_tx_active,
  input wire logic i_rx_active,
  input wire logic i_link_is_10m,
  input wire logic [15:0] o_mgmt_rdata,
  input wire logic o_mgmt_rvalid,
  input wire logic o_carrier_sense,
  input wire logic o_sqe_test_enable,
  input wire logic o_pwrdn_100,
  input wire logic o_pair_a_positive,
  input wire logic o_pair_a_oe_b,
  input wire logic o_pair_b_oe_b,
  input wire line_ctl_t o_line_ctl
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // read hits and line activity decoded once
  wire rd_hit = i_mgmt_req.rd && i_mgmt_req.addr == 5'h13;
  wire busy = i_tx_active || i_rx_active;
  a_read_answer: assert property (
    o_mgmt_rvalid == $past(rd_hit)) else $error("read answer wrong");
  a_node_bit: assert property (
    o_mgmt_rvalid |-> !o_mgmt_rdata[15]) else $error("node bit set");
  a_soft_bit: assert property (
    o_mgmt_rvalid |-> o_mgmt_rdata[14]) else $error("priority bit clear");
  a_sqe_default: assert property (
    o_sqe_test_enable) else $error("sqe test off");
  a_carrier_on: assert property (
    busy |=> o_carrier_sense) else $error("carrier missed");
  a_pwrdn_cause: assert property (
    o_pwrdn_100 |-> $past(i_link_is_10m)) else $error("stray power-down");
  a_one_driver: assert property (
    o_pair_a_oe_b || o_pair_b_oe_b) else $error("both pairs driven");
  a_idle_quiet: assert property (
    !o_line_ctl.tx_on_pair_a |-> !o_pair_a_positive)
    else $error("idle pair data");
  a_hiz_pair: assert property (
    o_line_ctl.pair_a_hiz |-> o_pair_a_oe_b) else $error("hiz pair driven");
  c_read: cover property (rd_hit);
  c_pwrdn: cover property (o_pwrdn_100);
  c_hiz: cover property (o_line_ctl.pair_a_hiz);
endmodule

/* File: bench/mgmt_station.sv */
// station management model: one-cycle register requests
`timescale 1ns/1ps
module mgmt_station
  import ext_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output mgmt_req_t o_req
);
  initial o_req = '0;
  // reserved bits forced to their zero defaults; no answer reads as all ones
  task automatic access(input logic w, input logic [4:0] a,
      input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clk_sys);
    o_req <= '{w, ~w, a, d & 16'hE381};
    @(posedge i_clk_sys);
    o_req <= '0;
    @(posedge i_clk_sys);
    q = i_rvalid ? i_rdata : 16'hFFFF;
  endtask
endmodule

/* File: bench/phy_extended_control_crossover_bench.sv */
// bench: read-back, pair selection, hunt and power-down
`timescale 1ns/1ps
module phy_extended_control_crossover_bench;
  import ext_ctrl_pkg::*;
  typedef struct packed {logic [15:0] w; logic pin; line_ctl_t e;} row_t;
  logic i_clk_sys, i_rst_b, i_partner_fault, i_auto_crossover_enable;
  logic i_link_energy, i_link_is_10m, i_tx_active, i_rx_active;
  logic i_line_tx_p, i_line_tx_n, o_mgmt_rvalid, o_carrier_sense, s;
  logic o_sqe_test_enable, o_pwrdn_100, o_pair_a_oe_b, o_pair_b_oe_b;
  logic o_pair_a_positive, o_pair_a_negative;
  logic o_pair_b_positive, o_pair_b_negative;
  logic [15:0] o_mgmt_rdata, q;
  mgmt_req_t i_mgmt_req;
  line_ctl_t o_line_ctl;
  int miscompares, checks, cyc;
  // the receive pair counts as high impedance too: at most one pair drives
  row_t rows [5] = '{'{16'h4000, 1, 4'hA}, '{16'h4100, 1, 4'h4},
    '{16'h4300, 0, 4'hA}, '{16'h4200, 0, 4'hA}, '{16'h4180, 1, 4'h6}};
  phy_extended_control_crossover DUT (.*);
  mgmt_station ms (.i_clk_sys(i_clk_sys), .i_rdata(o_mgmt_rdata),
    .i_rvalid(o_mgmt_rvalid), .o_req(i_mgmt_req));
  task automatic check(input logic [15:0] v, input logic [15:0] e);
    checks++;
    if (v !== e) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, v, e);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    i_clk_sys = 0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // line data toggles every cycle; a hang ends the run as a failure
  always @(posedge i_clk_sys) begin
    cyc++;
    i_line_tx_p <= cyc[0];
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    {i_rst_b, i_partner_fault, i_link_energy, i_link_is_10m} = '0;
    {i_tx_active, i_rx_active, i_line_tx_p, i_line_tx_n} = 4'h1;
    i_auto_crossover_enable = 1;
    repeat (5) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    ms.access(0, 5'h13, 0, q);
    check(q, 16'h4201);
    foreach (rows[i]) begin
      i_auto_crossover_enable <= rows[i].pin;
      i_tx_active <= rows[i].w[8];
      ms.access(1, 5'h13, rows[i].w, q);
      repeat (3) @(posedge i_clk_sys);
      check({12'h0, o_line_ctl}, {12'h0, rows[i].e});
      check({14'h0, o_pair_a_oe_b, o_pair_b_oe_b},
        {14'h0, rows[i].e.pair_a_hiz, rows[i].e.pair_b_hiz});
      check({15'h0, o_carrier_sense}, {15'h0, rows[i].w[8]});
    end
    i_partner_fault <= 1'b1;
    i_link_is_10m <= 1'b1;
    ms.access(1, 5'h13, 16'h4201, q);
    ms.access(0, 5'h13, 0, q);
    check(q, 16'h6201);
    check({15'h0, o_pwrdn_100}, 16'h0001);
    ms.access(0, 5'h12, 0, q);
    check(q, 16'hFFFF);
    ms.access(1, 5'h13, 16'hFFFF, q);
    ms.access(0, 5'h13, 0, q);
    check(q, 16'h6381);
    // hunt: swaps while no energy, then holds once energy is seen
    ms.access(1, 5'h13, 16'h4200, q);
    repeat (2) @(posedge i_clk_sys);
    s = o_line_ctl.tx_on_pair_a;
    repeat (8) @(posedge i_clk_sys);
    check({15'h0, o_line_ctl.tx_on_pair_a ^ s}, 16'h0001);
    i_link_energy <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    s = o_line_ctl.tx_on_pair_a;
    repeat (20) @(posedge i_clk_sys);
    check({15'h0, o_line_ctl.tx_on_pair_a}, {15'h0, s});
    final_report();
  end
endmodule
bind phy_extended_control_crossover ext_ctrl_checker u_chk (.*);

/* File: hdl/crossover_hunt.sv */
// automatic pair hunt: alternates assignments until energy is seen
`timescale 1ns/1ps
`include "ext_ctrl_defs.svh"
module crossover_hunt
  import ext_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_link_energy,
  output logic o_cross
);
  xover_state_t state_r;
  xover_state_t state_nxt;
  xover_state_t last_r;
  logic [3:0] cnt_r;
  wire cnt_done = (cnt_r == 4'(`PAIR_SWAP_ATTEMPT_CYC - 1));

  // next state: dwell on a choice, swap on timeout, lock once energy seen
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SEL_STRAIGHT: begin
        if (i_link_energy) state_nxt = SEL_LOCKED;
        else if (cnt_done) state_nxt = SEL_CROSS;
      end
      SEL_CROSS: begin
        if (i_link_energy) state_nxt = SEL_LOCKED;
        else if (cnt_done) state_nxt = SEL_STRAIGHT;
      end
      SEL_LOCKED: begin
        if (!i_link_energy) state_nxt = last_r;
      end
      default: state_nxt = SEL_STRAIGHT;
    endcase
  end

  // hunting restarts from straight whenever auto mode is off
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !i_enable) begin
      state_r <= SEL_STRAIGHT;
      last_r <= SEL_STRAIGHT;
      cnt_r <= 4'h0;
      o_cross <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != SEL_LOCKED) last_r <= state_r;
      cnt_r <= (cnt_done || state_nxt != state_r) ? 4'h0 : cnt_r + 4'h1;
      o_cross <= (state_nxt == SEL_CROSS) ||
                 (state_nxt == SEL_LOCKED && state_r == SEL_CROSS) ||
                 (state_nxt == SEL_LOCKED && state_r == SEL_LOCKED &&
                  o_cross);
    end
  end
endmodule

/* File: hdl/ext_ctrl_defs.svh */
// offsets, field positions, reset values and timing counts for the block
`ifndef EXT_CTRL_DEFS_SVH
`define EXT_CTRL_DEFS_SVH
`define EXT_CTRL_TWO_ADDR 5'h13
`define BIT_NODE_STATUS 15
`define BIT_SW_PRIORITY 14
`define BIT_REMOTE_FAULT 13
`define BIT_AUTO_XOVER_EN 9
`define BIT_FORCED_PAIR 8
`define BIT_PAIR_HIZ 7
`define BIT_AUTO_PWRDN 0
`define EXT_CTRL_TWO_RESET 16'h4201
`define EXT_CTRL_WR_MASK 16'h1BFF
`define PAIR_SWAP_ATTEMPT_NS 64
`define CLK_PERIOD_NS 8
`define PAIR_SWAP_ATTEMPT_CYC (`PAIR_SWAP_ATTEMPT_NS / `CLK_PERIOD_NS)
`endif

/* File: hdl/ext_ctrl_pkg.sv */
// types shared by the extended control block
package ext_ctrl_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;
  typedef struct packed {
    logic tx_on_pair_a;
    logic pair_a_hiz;
    logic pair_b_hiz;
    logic pwrdn_100;
  } line_ctl_t;
  typedef enum logic [2:0] {
    SEL_STRAIGHT = 3'b001,
    SEL_CROSS = 3'b010,
    SEL_LOCKED = 3'b100
  } xover_state_t;
endpackage

/* File: hdl/phy_extended_control_crossover.sv */
// extended control register two and the pair crossover selection
// What this block and its surroundings must do
// (RQ1) node/repeater status bit always reads 0, read-only
// (RQ2) signal-quality-error test generation enabled by default in node mode
// (RQ3) carrier sense asserted on transmit or receive activity
// (RQ4) priority status bit always reads 1, software mode, read-only
// (RQ5) remote fault bit mirrors partner's fault from link control word
// (RQ6) management writes reserved bits with their default values
// (RQ7) register enable 0: ignore pin, forced-pair bit picks straight/cross
// (RQ8) pin low with register enable 1 forces straight assignment
// (RQ9) pin and register enable both 1: automatic cable-matching selection
// (RQ10) straight transmits on A, receives on B; cross swaps them
// (RQ11) reset: enable 1, forced-pair 0; pin pulled high externally
// (RQ12) tri-state bit 1 puts transmit outputs in high impedance
// (RQ13) power-down bit 1 and 10 Mb/s link switches off 100 Mb/s part
// (RQ14) tri-state acts on whichever pair currently transmits
`timescale 1ns/1ps
`include "ext_ctrl_defs.svh"
module phy_extended_control_crossover
  import ext_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire mgmt_req_t i_mgmt_req,
  input wire logic i_partner_fault,
  input wire logic i_auto_crossover_enable,
  input wire logic i_link_energy,
  input wire logic i_link_is_10m,
  input wire logic i_tx_active,
  input wire logic i_rx_active,
  input wire logic i_line_tx_p,
  input wire logic i_line_tx_n,
  output logic [15:0] o_mgmt_rdata,
  output logic o_mgmt_rvalid,
  output logic o_carrier_sense,
  output logic o_sqe_test_enable,
  output logic o_pwrdn_100,
  output logic o_pair_a_positive,
  output logic o_pair_a_negative,
  output logic o_pair_b_positive,
  output logic o_pair_b_negative,
  output logic o_pair_a_oe_b,
  output logic o_pair_b_oe_b,
  output line_ctl_t o_line_ctl
);
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic fault_r;
  logic auto_cross;

  // decode of the management request
  wire hit = (i_mgmt_req.addr == `EXT_CTRL_TWO_ADDR);
  wire wr_hit = i_mgmt_req.wr && hit;
  wire rd_hit = i_mgmt_req.rd && hit;

  // only writable bits take the written value; read-only bits keep reset
  // value so a careless write cannot flip the fixed mode bits
  assign ctrl_nxt = wr_hit ?
    ((i_mgmt_req.wdata & `EXT_CTRL_WR_MASK) |
     (ctrl_r & ~`EXT_CTRL_WR_MASK)) : ctrl_r; // RQ6

  // control register storage
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ctrl_r <= `EXT_CTRL_TWO_RESET; // RQ11
      fault_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      fault_r <= i_partner_fault; // RQ5
    end
  end

  wire reg_auto_en = ctrl_r[`BIT_AUTO_XOVER_EN];
  wire forced_pair_select = ctrl_r[`BIT_FORCED_PAIR];
  wire pair_output_hiz = ctrl_r[`BIT_PAIR_HIZ];
  wire auto_pwrdn = ctrl_r[`BIT_AUTO_PWRDN];
  wire hunt_on = reg_auto_en && i_auto_crossover_enable; // RQ9

  // automatic hunting only runs while both enables are 1
  crossover_hunt u_hunt (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_enable(hunt_on),
    .i_link_energy(i_link_energy),
    .o_cross(auto_cross)
  );

  // pair selection: register off forces bit, pin low forces straight
  wire sel_cross = !reg_auto_en ? forced_pair_select : // RQ7
                   !i_auto_crossover_enable ? 1'b0 : // RQ8
                   auto_cross; // RQ9

  // assembled read value with fixed mode bits
  wire [15:0] rd_value = {1'b0, // RQ1
                          1'b1, // RQ4
                          fault_r, // RQ5
                          ctrl_r[12:0]};

  // read port, carrier sense and power-down, all registered
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_mgmt_rdata <= 16'h0000;
      o_mgmt_rvalid <= 1'b0;
      o_carrier_sense <= 1'b0;
      o_sqe_test_enable <= 1'b1;
      o_pwrdn_100 <= 1'b0;
    end else begin
      o_mgmt_rvalid <= rd_hit;
      if (rd_hit) o_mgmt_rdata <= rd_value;
      o_carrier_sense <= i_tx_active || i_rx_active; // RQ3
      o_sqe_test_enable <= 1'b1; // RQ2
      o_pwrdn_100 <= auto_pwrdn && i_link_is_10m; // RQ13
    end
  end

  // line steering: transmitter pair driven, receiver pair left to input;
  // hiz follows the chosen pair so both configurations are silenced
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_pair_a_positive <= 1'b0;
      o_pair_a_negative <= 1'b0;
      o_pair_b_positive <= 1'b0;
      o_pair_b_negative <= 1'b0;
      o_pair_a_oe_b <= 1'b1;
      o_pair_b_oe_b <= 1'b1;
      o_line_ctl <= '0;
    end else begin
      o_pair_a_positive <= sel_cross ? 1'b0 : i_line_tx_p; // RQ10
      o_pair_a_negative <= sel_cross ? 1'b0 : i_line_tx_n; // RQ10
      o_pair_b_positive <= sel_cross ? i_line_tx_p : 1'b0; // RQ10
      o_pair_b_negative <= sel_cross ? i_line_tx_n : 1'b0; // RQ10
      o_pair_a_oe_b <= sel_cross || pair_output_hiz; // RQ12 RQ14
      o_pair_b_oe_b <= !sel_cross || pair_output_hiz; // RQ12 RQ14
      o_line_ctl.tx_on_pair_a <= !sel_cross;
      o_line_ctl.pair_a_hiz <= sel_cross || pair_output_hiz;
      o_line_ctl.pair_b_hiz <= !sel_cross || pair_output_hiz;
      o_line_ctl.pwrdn_100 <= auto_pwrdn && i_link_is_10m;
    end
  end
endmodule
